// file: core/adc_mode_pin_control.sv
// Functional notes
// - mode-select low means serial programming, high means pin straps
// - power-down input high puts the device into power-down
// - in strap mode, power-down falling edge resets the control register (interrupt mask keeps its value)
// - data pin is serial data in serial mode, format strap otherwise
// - clock pin is serial clock in serial mode, divider strap otherwise
// - select pin is port select in serial mode, bus-mode strap otherwise
// - each channel has own 10-bit three-state bus, bit 0 is LSB
// - each channel drives its own over-range flag and data clock
// - grounded negative clock input means single-ended clock, else differential
// - bus strap low dual, high muxed on A, open muxed on B
`timescale 1ns/1ps
`include "adc_pin_defines.svh"

module adc_mode_pin_control
    import adc_pin_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // mode and control pins
    input  wire logic        serial_mode_select_n,
    input  wire logic        power_down_input,
    input  wire logic        clk_neg_grounded,
    input  wire logic        sync_input,
    // shared pins with float sense
    input  wire logic        serial_in_format_pin_i,
    output logic             serial_in_format_pin_o,
    output logic             serial_in_format_pin_oe,
    input  wire logic        serial_in_format_float,
    input  wire logic        serial_clock_div_pin,
    input  wire logic        serial_clock_div_float,
    input  wire logic        port_select_bus_mode_pin,
    input  wire logic        port_select_bus_mode_float,
    // serial port side
    output logic             spi_data_in,
    output logic             spi_clock,
    output logic             spi_select_n,
    input  wire logic        spi_data_out,
    input  wire logic        spi_data_out_en,
    // converter core side, offset binary
    input  wire logic [9:0]  conv_sample_a,
    input  wire logic [9:0]  conv_sample_b,
    input  wire logic        conv_over_a,
    input  wire logic        conv_over_b,
    // channel outputs
    output logic      [9:0]  sample_bus_chan_a,
    output logic             sample_bus_chan_a_oe,
    output logic      [9:0]  sample_bus_chan_b,
    output logic             sample_bus_chan_b_oe,
    output logic             over_range_chan_a,
    output logic             over_range_chan_b,
    output logic             data_clock_chan_a,
    output logic             data_clock_chan_b,
    // status
    output logic             power_down,
    output logic             clock_single_ended,
    output logic             irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [`CTRL_WIDTH-1:0] ctrl_reg;
    logic [`IRQ_WIDTH-1:0]  irq_stat_reg;
    logic [`IRQ_WIDTH-1:0]  irq_stat_next;
    logic [`IRQ_WIDTH-1:0]  irq_mask_reg;
    logic [`IRQ_WIDTH-1:0]  irq_event;
    level_t                 fmt_strap;
    level_t                 div_strap;
    level_t                 bus_strap;
    logic                   parallel_mode;
    logic [1:0]             eff_fmt;
    logic [1:0]             eff_div;
    logic [1:0]             eff_bus;
    logic                   pd_prev_reg;
    logic                   cfg_reset;
    logic                   sync_prev_reg;
    logic                   sync_rise;
    logic [1:0]             div_cnt_reg;
    logic [1:0]             div_max;
    logic                   tick;
    logic                   take;
    phase_t                 phase_reg;
    logic [9:0]             held_b_reg;
    logic                   held_over_b_reg;
    logic                   upd_a_reg;
    logic                   upd_b_reg;
    logic                   apb_setup;
    logic                   apb_access;
    logic                   addr_ok;

    // ------------------------------------------------------------
    // data format conversion from offset binary
    // ------------------------------------------------------------
    function automatic logic [9:0] fmt_conv(input logic [9:0] s,
                                            input logic [1:0] f);
        case (f)
            FMT_TWOS: fmt_conv = {~s[9], s[8:0]};
            FMT_GRAY: fmt_conv = s ^ {1'b0, s[9:1]};
            default:  fmt_conv = s;
        endcase
    endfunction

    // ------------------------------------------------------------
    // mode select and pin sharing
    // ------------------------------------------------------------
    strap_decoder u_fmt_strap (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_level  (serial_in_format_pin_i),
        .pin_float  (serial_in_format_float),
        .level_code (fmt_strap)
    );

    strap_decoder u_div_strap (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_level  (serial_clock_div_pin),
        .pin_float  (serial_clock_div_float),
        .level_code (div_strap)
    );

    strap_decoder u_bus_strap (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_level  (port_select_bus_mode_pin),
        .pin_float  (port_select_bus_mode_float),
        .level_code (bus_strap)
    );

    // mode select level picks the pin role
    assign parallel_mode = serial_mode_select_n;

    // serial port sees the pins only in serial mode
    assign spi_data_in  = parallel_mode ? 1'b0 : serial_in_format_pin_i;
    assign spi_clock    = parallel_mode ? 1'b0 : serial_clock_div_pin;
    assign spi_select_n = parallel_mode ? 1'b1 : port_select_bus_mode_pin;
    assign serial_in_format_pin_o  = spi_data_out;
    assign serial_in_format_pin_oe = !parallel_mode && spi_data_out_en;

    // effective settings: straps in parallel mode, register otherwise
    assign eff_fmt = parallel_mode ? fmt_strap
                   : ctrl_reg[`CTRL_FMT_LSB +: 2];
    assign eff_div = parallel_mode ? div_strap
                   : ctrl_reg[`CTRL_DIV_LSB +: 2];
    assign eff_bus = parallel_mode ? bus_strap
                   : ctrl_reg[`CTRL_BUS_LSB +: 2];

    // ------------------------------------------------------------
    // power-down and configuration reset
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_prev_reg        <= 1'b0;
            power_down         <= 1'b0;
            clock_single_ended <= 1'b0;
            sync_prev_reg      <= 1'b0;
        end else begin
            pd_prev_reg        <= power_down_input;
            power_down         <= power_down_input;
            clock_single_ended <= clk_neg_grounded;
            sync_prev_reg      <= sync_input;
        end
    end

    assign cfg_reset = parallel_mode && pd_prev_reg && !power_down_input;
    assign sync_rise = sync_input && !sync_prev_reg;

    // ------------------------------------------------------------
    // apb slave, zero wait states, unmapped address flags error
    // ------------------------------------------------------------
    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign pready     = apb_access;
    assign addr_ok    = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS)
                     || (paddr == `OFS_IRQ_STAT) || (paddr == `OFS_IRQ_MASK);
    assign pslverr    = apb_access && !addr_ok;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `OFS_CTRL:     prdata[`CTRL_WIDTH-1:0] <= ctrl_reg;
                `OFS_STATUS: begin
                    prdata[`STAT_PARALLEL]     <= parallel_mode;
                    prdata[`STAT_PDOWN]        <= power_down;
                    prdata[`STAT_SE_CLK]       <= clock_single_ended;
                    prdata[`STAT_FMT_LSB +: 2] <= eff_fmt;
                    prdata[`STAT_DIV_LSB +: 2] <= eff_div;
                    prdata[`STAT_BUS_LSB +: 2] <= eff_bus;
                end
                `OFS_IRQ_STAT: prdata[`IRQ_WIDTH-1:0] <= irq_stat_reg;
                `OFS_IRQ_MASK: prdata[`IRQ_WIDTH-1:0] <= irq_mask_reg;
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // control register, strap-mode power-down release resets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (cfg_reset) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (apb_access && pwrite && paddr == `OFS_CTRL) begin
            ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `IRQ_RESET;
        end else if (apb_access && pwrite && paddr == `OFS_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // sticky status, read clears, a new event wins over the clear
    // ------------------------------------------------------------
    always_comb begin
        irq_event = '0;
        irq_event[`IRQ_CFG_RESET] = cfg_reset;
        irq_event[`IRQ_OVR_A]     = upd_a_reg && over_range_chan_a;
        irq_event[`IRQ_OVR_B]     = upd_b_reg && over_range_chan_b;
        irq_event[`IRQ_SYNC]      = sync_rise;
        irq_stat_next = irq_stat_reg;
        // clear only what the setup cycle reported, later events stay
        if (apb_access && !pwrite && paddr == `OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~prdata[`IRQ_WIDTH-1:0];
        end
        irq_stat_next = irq_stat_next | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= `IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // clock divider, realigned by the sync input
    // ------------------------------------------------------------
    always_comb begin
        case (eff_div)
            DIV_2:   div_max = `DIV_CNT_MAX2;
            DIV_4:   div_max = `DIV_CNT_MAX4;
            default: div_max = `DIV_CNT_MAX1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 2'h0;
        end else if (sync_rise || div_cnt_reg >= div_max) begin
            div_cnt_reg <= 2'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 2'h1;
        end
    end

    assign tick = (div_cnt_reg >= div_max) && !sync_rise && !power_down_input;
    // muxed bus needs two cycles per sample, so a tick in phase a is dropped
    assign take = tick && (phase_reg != PH_A);

    // ------------------------------------------------------------
    // multiplexed bus phase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_IDLE;
        end else begin
            case (phase_reg)
                PH_IDLE, PH_B: begin
                    if (take && eff_bus != BUS_DUAL) begin
                        phase_reg <= PH_A;
                    end else begin
                        phase_reg <= PH_IDLE;
                    end
                end
                PH_A:    phase_reg <= PH_B;
                default: phase_reg <= PH_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // channel output registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_bus_chan_a <= 10'h000;
            sample_bus_chan_b <= 10'h000;
            over_range_chan_a <= 1'b0;
            over_range_chan_b <= 1'b0;
            held_b_reg        <= 10'h000;
            held_over_b_reg   <= 1'b0;
            upd_a_reg         <= 1'b0;
            upd_b_reg         <= 1'b0;
        end else begin
            upd_a_reg <= 1'b0;
            upd_b_reg <= 1'b0;
            if (take && eff_bus == BUS_DUAL) begin
                sample_bus_chan_a <= fmt_conv(conv_sample_a, eff_fmt);
                sample_bus_chan_b <= fmt_conv(conv_sample_b, eff_fmt);
                over_range_chan_a <= conv_over_a;
                over_range_chan_b <= conv_over_b;
                upd_a_reg         <= 1'b1;
                upd_b_reg         <= 1'b1;
            end else if (take && eff_bus == BUS_MUX_B) begin
                sample_bus_chan_b <= fmt_conv(conv_sample_a, eff_fmt);
                over_range_chan_b <= conv_over_a;
                held_b_reg        <= conv_sample_b;
                held_over_b_reg   <= conv_over_b;
                upd_b_reg         <= 1'b1;
            end else if (take) begin
                sample_bus_chan_a <= fmt_conv(conv_sample_a, eff_fmt);
                over_range_chan_a <= conv_over_a;
                held_b_reg        <= conv_sample_b;
                held_over_b_reg   <= conv_over_b;
                upd_a_reg         <= 1'b1;
            end else if (phase_reg == PH_A && eff_bus == BUS_MUX_B) begin
                sample_bus_chan_b <= fmt_conv(held_b_reg, eff_fmt);
                over_range_chan_b <= held_over_b_reg;
                upd_b_reg         <= 1'b1;
            end else if (phase_reg == PH_A) begin
                sample_bus_chan_a <= fmt_conv(held_b_reg, eff_fmt);
                over_range_chan_a <= held_over_b_reg;
                upd_a_reg         <= 1'b1;
            end
        end
    end

    // data clocks rise one cycle after their data, enables follow mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_clock_chan_a    <= 1'b0;
            data_clock_chan_b    <= 1'b0;
            sample_bus_chan_a_oe <= 1'b0;
            sample_bus_chan_b_oe <= 1'b0;
        end else begin
            data_clock_chan_a    <= upd_a_reg;
            data_clock_chan_b    <= upd_b_reg;
            sample_bus_chan_a_oe <= !power_down_input
                                 && eff_bus != BUS_MUX_B;
            sample_bus_chan_b_oe <= !power_down_input
                                 && eff_bus != BUS_MUX_A;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_dual_take;
        take && eff_bus == BUS_DUAL;
    endsequence

    sequence s_dclk_pulse;
        ##1 upd_a_reg ##1 data_clock_chan_a;
    endsequence

    a_pd_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        power_down_input |=> !sample_bus_chan_a_oe && !sample_bus_chan_b_oe)
        else $error("bus enabled during power-down");

    a_cfg_reset_fall: assert property (@(posedge pclk)
        disable iff (!presetn)
        parallel_mode && $fell(power_down_input)
        |=> ctrl_reg == `CTRL_RESET)
        else $error("config not reset on power-down release");

    a_serial_ignored: assert property (@(posedge pclk)
        disable iff (!presetn)
        parallel_mode |-> spi_select_n && !spi_clock && !spi_data_in
                          && !serial_in_format_pin_oe)
        else $error("serial activity passed in strap mode");

    a_fmt_strap: assert property (@(posedge pclk) disable iff (!presetn)
        (parallel_mode && !serial_in_format_float
         && serial_in_format_pin_i)[*2]
        |-> eff_fmt == FMT_OFFSET)
        else $error("format strap high not offset binary");

    a_bit_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_dual_take ##0 (eff_fmt == FMT_OFFSET)
        |=> sample_bus_chan_a == $past(conv_sample_a))
        else $error("channel a bus bit order wrong");

    a_dclk_follow: assert property (@(posedge pclk) disable iff (!presetn)
        s_dual_take |-> s_dclk_pulse)
        else $error("data clock did not follow sample");

    a_sync_align: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sync_input) |=> div_cnt_reg == 2'h0 ##1 div_cnt_reg != 2'h0
                                                      || div_max == 2'h0)
        else $error("divider not realigned by sync");

    a_mux_order: assert property (@(posedge pclk) disable iff (!presetn)
        phase_reg == PH_A |=> phase_reg == PH_B && (upd_a_reg || upd_b_reg))
        else $error("muxed bus second word missing");

    a_se_clock: assert property (@(posedge pclk) disable iff (!presetn)
        clk_neg_grounded[*2] |-> clock_single_ended)
        else $error("single-ended clock not flagged");

    a_mode_pins: assert property (@(posedge pclk) disable iff (!presetn)
        !serial_mode_select_n ##1 !serial_mode_select_n
        |-> spi_select_n == port_select_bus_mode_pin)
        else $error("serial mode select not routed");

endmodule

// file: core/adc_pin_defines.svh
`ifndef ADC_PIN_DEFINES_SVH
`define ADC_PIN_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_MASK  8'h0c

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_FMT_LSB  0
`define CTRL_DIV_LSB  2
`define CTRL_BUS_LSB  4
`define CTRL_WIDTH    6
`define CTRL_RESET    6'h00

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STAT_PARALLEL 0
`define STAT_PDOWN    1
`define STAT_SE_CLK   2
`define STAT_FMT_LSB  4
`define STAT_DIV_LSB  6
`define STAT_BUS_LSB  8

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define IRQ_CFG_RESET 0
`define IRQ_OVR_A     1
`define IRQ_OVR_B     2
`define IRQ_SYNC      3
`define IRQ_WIDTH     4
`define IRQ_RESET     4'h0

// ----------------------------------------------------------------
// sample data and divider
// ----------------------------------------------------------------
`define SAMPLE_WIDTH  10
`define DIV_CNT_MAX1  2'h0
`define DIV_CNT_MAX2  2'h1
`define DIV_CNT_MAX4  2'h3

`endif

// file: core/adc_pin_pkg.sv
package adc_pin_pkg;

    // three-level strap reading
    typedef enum logic [1:0] {
        LVL_LOW  = 2'h0,
        LVL_HIGH = 2'h1,
        LVL_OPEN = 2'h2
    } level_t;

    // output data format
    typedef enum logic [1:0] {
        FMT_TWOS   = 2'h0,
        FMT_OFFSET = 2'h1,
        FMT_GRAY   = 2'h2
    } fmt_t;

    // clock divider mode
    typedef enum logic [1:0] {
        DIV_1 = 2'h0,
        DIV_2 = 2'h1,
        DIV_4 = 2'h2
    } div_t;

    // output bus mode
    typedef enum logic [1:0] {
        BUS_DUAL  = 2'h0,
        BUS_MUX_A = 2'h1,
        BUS_MUX_B = 2'h2
    } bus_t;

    // multiplexed bus phase, gray along idle -> a -> b
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_A    = 2'b01,
        PH_B    = 2'b11
    } phase_t;

endpackage

// file: core/strap_decoder.sv
`timescale 1ns/1ps
`include "adc_pin_defines.svh"

module strap_decoder
    import adc_pin_pkg::*;
(
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // pad sense
    input  wire logic   pin_level,
    input  wire logic   pin_float,
    // decoded level
    output level_t      level_code
);

    // ------------------------------------------------------------
    // three-level decode, float sense wins over the logic level
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_code <= LVL_LOW;
        end else if (pin_float) begin
            level_code <= LVL_OPEN;
        end else begin
            level_code <= pin_level ? LVL_HIGH : LVL_LOW;
        end
    end

endmodule

// file: tb/capture_model.sv
`timescale 1ns/1ps

module capture_model (
    // clock
    input  wire logic       pclk,
    // channel a
    input  wire logic [9:0] bus_a,
    input  wire logic       dclk_a,
    input  wire logic       ovr_a,
    // channel b
    input  wire logic [9:0] bus_b,
    input  wire logic       dclk_b,
    // captured words
    output logic      [9:0] word_a,
    output logic      [9:0] word_b,
    output logic            ovr_seen
);
    logic [9:0] bus_a_d;
    logic [9:0] bus_b_d;
    logic       ovr_a_d;

    // data leads its clock by one cycle, so keep last cycle's bus
    always_ff @(posedge pclk) begin
        bus_a_d <= bus_a;
        bus_b_d <= bus_b;
        ovr_a_d <= ovr_a;
    end

    // ------------------------------------------------------------
    // capture on each channel's own data clock
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (dclk_a) begin
            word_a <= bus_a_d;
            ovr_seen <= ovr_a_d;
        end
    end
    // channel b is qualified only by its own clock
    always_ff @(posedge pclk) begin
        if (dclk_b) begin
            word_b <= bus_b_d;
        end
    end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
    import adc_pin_pkg::*;
    typedef struct {logic [1:0] lvl; logic se; logic [31:0] stat;} row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        serial_mode_select_n, power_down_input, clk_neg_grounded;
    logic        sync_input, serial_in_format_pin_i, serial_in_format_pin_o;
    logic        serial_in_format_pin_oe, serial_in_format_float;
    logic        serial_clock_div_pin, serial_clock_div_float;
    logic        port_select_bus_mode_pin, port_select_bus_mode_float;
    logic        spi_data_in, spi_clock, spi_select_n, spi_data_out;
    logic        spi_data_out_en, conv_over_a, conv_over_b, irq, ovr_seen;
    logic [9:0]  conv_sample_a, conv_sample_b, sample_bus_chan_a;
    logic [9:0]  sample_bus_chan_b, word_a, word_b;
    logic        sample_bus_chan_a_oe, sample_bus_chan_b_oe;
    logic        over_range_chan_a, over_range_chan_b, data_clock_chan_a;
    logic        data_clock_chan_b, power_down, clock_single_ended;
    int          miscompares, checked;
    row_t        rows [3] = '{'{2'h0, 1'h1, 32'h005},
                              '{2'h1, 1'h0, 32'h151},
                              '{2'h2, 1'h1, 32'h2a5}};

    adc_mode_pin_control dut (.*);

    capture_model far_end (.pclk(pclk), .bus_a(sample_bus_chan_a),
        .dclk_a(data_clock_chan_a), .ovr_a(over_range_chan_a),
        .bus_b(sample_bus_chan_b), .dclk_b(data_clock_chan_b),
        .word_a(word_a), .word_b(word_b), .ovr_seen(ovr_seen));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // one apb transfer, read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    // about 80 cycles expected, cut off well beyond
    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {serial_mode_select_n, power_down_input, clk_neg_grounded} = '0;
        {sync_input, serial_in_format_pin_i, serial_in_format_float} = '0;
        {serial_clock_div_pin, serial_clock_div_float} = '0;
        {port_select_bus_mode_pin, port_select_bus_mode_float} = '0;
        {spi_data_out, spi_data_out_en, conv_over_a, conv_over_b} = '0;
        {conv_sample_a, conv_sample_b} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 8'h0c, 32'h0);
        chk(rd, 32'h0, "mask reset value");
        serial_mode_select_n <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            {serial_in_format_pin_i, serial_clock_div_pin,
             port_select_bus_mode_pin} <= {3{rows[i].lvl == 2'h1}};
            {serial_in_format_float, serial_clock_div_float,
             port_select_bus_mode_float} <= {3{rows[i].lvl == 2'h2}};
            clk_neg_grounded <= rows[i].se;
            repeat (3) @(posedge pclk);
            apb(1'h0, 8'h04, 32'h0);
            chk(rd[9:0], rows[i].stat, "strap status");
            chk(clock_single_ended, rows[i].se, "clock kind");
            chk({spi_data_in, spi_clock, spi_select_n}, 3'h1, "spi");
        end
        $display("strap rows done");
        {serial_in_format_float, serial_clock_div_float} <= '0;
        {port_select_bus_mode_pin, port_select_bus_mode_float} <= 2'h2;
        {serial_in_format_pin_i, serial_clock_div_pin} <= 2'h2;
        serial_mode_select_n <= 1'h0;
        spi_data_out_en <= 1'h1;
        repeat (2) @(posedge pclk);
        chk({spi_data_in, spi_clock, spi_select_n, serial_in_format_pin_oe},
            4'hb, "pass");
        apb(1'h1, 8'h00, 32'h1);
        conv_sample_a <= 10'h2a5;
        conv_sample_b <= 10'h15a;
        conv_over_a <= 1'h1;
        repeat (6) @(posedge pclk);
        chk({word_a, word_b}, {10'h2a5, 10'h15a}, "words");
        chk({ovr_seen, over_range_chan_b}, 2'h2, "over range");
        conv_over_a <= 1'h0;
        power_down_input <= 1'h1;
        repeat (3) @(posedge pclk);
        chk({power_down, sample_bus_chan_a_oe, sample_bus_chan_b_oe}, 3'h4,
            "power down");
        power_down_input <= 1'h0;
        repeat (3) @(posedge pclk);
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h1, "serial ctrl kept");
        $display("serial mode done");
        apb(1'h1, 8'h0c, 32'h1);
        apb(1'h0, 8'h08, 32'h0);
        serial_mode_select_n <= 1'h1;
        sync_input <= 1'h1;
        repeat (2) @(posedge pclk);
        sync_input <= 1'h0;
        power_down_input <= 1'h1;
        repeat (3) @(posedge pclk);
        power_down_input <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(irq, 1'h1, "irq raised");
        apb(1'h0, 8'h08, 32'h0);
        chk(rd[3:0], 4'h9, "events");
        chk(irq, 1'h0, "irq cleared");
        serial_mode_select_n <= 1'h0;
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0, "ctrl reset by strap power down");
        apb(1'h1, 8'h20, 32'h3);
        chk(err, 1'h1, "unmapped refused");
        $display("irq and reset done");
        end_sim();
    end
endmodule
